// File: logic/pis_pkg.sv
// Constants for the peripheral input select block and its port B registers.
// Assumes a 16-bit register view carried in the low half of a 32-bit bus.
package pis_pkg;

  // --------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // --------------------------------------------------------------------------
  localparam logic [11:0] IDX_DIRB     = 12'hE10;
  localparam logic [11:0] IDX_PORTRD   = 12'hE12;
  localparam logic [11:0] IDX_LATCH    = 12'hE14;
  localparam logic [11:0] IDX_ODRAIN   = 12'hE16;
  localparam logic [11:0] IDX_CNEN     = 12'hE18;
  localparam logic [11:0] IDX_PULLUP   = 12'hE1A;
  localparam logic [11:0] IDX_PULLDN   = 12'hE1C;
  localparam logic [11:0] IDX_ANSEL    = 12'hE1E;
  localparam logic [11:0] IDX_SEL_BASE = 12'h680;

  // --------------------------------------------------------------------------
  // Reset values and implemented-bit masks
  // --------------------------------------------------------------------------
  localparam logic [15:0] RST_DIR      = 16'hFFFF;
  localparam logic [15:0] RST_ZERO     = 16'h0000;
  localparam logic [15:0] RST_ANSEL    = 16'h010F;
  localparam logic [15:0] ANSEL_MASK   = 16'h010F;
  localparam logic [6:0]  RST_SEL      = 7'h00;

  // --------------------------------------------------------------------------
  // Selector codes
  // --------------------------------------------------------------------------
  localparam int unsigned SEL_W        = 7;
  localparam logic [6:0]  CODE_VSS     = 7'h00;
  localparam logic [6:0]  CODE_CMP_ONE = 7'h01;
  localparam int unsigned CODE_CMP_LO  = 1;
  localparam int unsigned CODE_TRG_LO  = 6;
  localparam int unsigned CODE_ENC_LO  = 10;
  localparam int unsigned CODE_PIN_LO  = 20;
  localparam logic [6:0]  CODE_PIN_HI  = 7'h79;
  localparam int unsigned NUM_CMP      = 4;
  localparam int unsigned NUM_TRG      = 4;
  localparam int unsigned NUM_ENC      = 4;

  // --------------------------------------------------------------------------
  // Selector slots
  // --------------------------------------------------------------------------
  localparam int unsigned SLOT_FAULT_A = 0;
  localparam int unsigned SLOT_FLT1    = 1;

endpackage

// File: logic/pis_input_select.sv
// Peripheral input selector with the port B control registers, on Wishbone.
// Assumes classic Wishbone, 32-bit data; pads arrive asynchronously while the
// comparator, trigger and encoder sources are logic on the same clock.
//
// Behaviour
// RL1: Each peripheral input has a 7-bit selector; value N picks remappable pin N.
// RL2: Mapping is per peripheral input; several inputs may pick the same pin.
// RL3: Software programs only selector values the device variant supports.
// RL4: Fault A selector sits in bits 6-0 of its register and picks its source.
// RL5: Fault A register bits 15-7 read zero and ignore writes.
// RL6: Code 1111001 selects input-only pin 121, the highest code.
// RL7: Code 0000001 selects comparator one output internally, no pin used.
// RL8: Code 0000000 ties the peripheral input to constant low.
// RL9: Selectors also offer comparator and trigger generator outputs as sources.
// RL10: Motor variants also offer filtered encoder index and home of both channels.
// RL11: PWM fault 1 selector at 0000001 is driven by comparator one output.
// RL12: Software enables the encoder and maps its pins before filter use.
// RL13: Port B pin read and output latch have undefined contents after reset.
// RL14: Unimplemented port B bits read zero; analog select resets to 010F.
// RL15: A selector code with no implemented source gives constant low.
module pis_input_select
  import pis_pkg::*;
#(
  parameter int unsigned NUM_SEL   = 4,
  parameter int unsigned NUM_RP    = 102,
  parameter bit          MOTOR_VAR = 1'b1
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic [15:0]        adr_i,
  input  wire logic [31:0]        dat_i,
  output logic      [31:0]        dat_o,
  input  wire logic               we_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  output logic                    ack_o,
  input  wire logic [NUM_RP-1:0]  rp_pad_i,
  input  wire logic [NUM_CMP-1:0] cmp_out_i,
  input  wire logic [NUM_TRG-1:0] trg_out_i,
  input  wire logic [NUM_ENC-1:0] enc_filt_i,
  output logic      [NUM_SEL-1:0] periph_in_o,
  input  wire logic [15:0]        port_b_pin_read_pad_i,
  output logic      [15:0]        port_b_pin_read_out_o,
  output logic      [15:0]        port_b_pin_read_oe_o,
  output logic      [15:0]        port_b_pin_read_pu_o,
  output logic      [15:0]        port_b_pin_read_pd_o,
  output logic      [15:0]        port_b_pin_read_ansel_o,
  output logic                    cn_change_o
);

  localparam int unsigned NP = NUM_RP + 16;

  // --------------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------------
  function automatic logic hit(input logic [15:0] a, input logic [11:0] idx);
    hit = (a[15:14] == 2'b00) && (a[13:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [15:0] lane_mask(input logic [3:0] s);
    lane_mask = {{8{s[1]}}, {8{s[0]}}};
  endfunction

  // --------------------------------------------------------------------------
  // Pad synchronisers: a level counts once stages two and three agree
  // --------------------------------------------------------------------------
  logic [NP-1:0] pad_s1;
  logic [NP-1:0] pad_s2;
  logic [NP-1:0] pad_s3;
  logic [NP-1:0] pad_filt;
  logic [NP-1:0] next_filt;

  always_comb begin
    next_filt = pad_filt;
    for (int i = 0; i < NP; i++) begin
      if (pad_s2[i] == pad_s3[i]) begin
        next_filt[i] = pad_s3[i];
      end
    end
  end

  // No reset here, so the pin view is undefined until pads settle. [RL13]
  always_ff @(posedge clk_i) begin
    pad_s1   <= {port_b_pin_read_pad_i, rp_pad_i};
    pad_s2   <= pad_s1;
    pad_s3   <= pad_s2;
    pad_filt <= next_filt;
  end

  // --------------------------------------------------------------------------
  // Source vector indexed by selector code
  // --------------------------------------------------------------------------
  logic [127:0] src;

  always_comb begin
    src = '0;                                      // [RL8] [RL15]
    for (int i = 0; i < NUM_CMP; i++) begin
      src[CODE_CMP_LO + i] = cmp_out_i[i];         // [RL7] [RL9]
    end
    for (int i = 0; i < NUM_TRG; i++) begin
      src[CODE_TRG_LO + i] = trg_out_i[i];         // [RL9]
    end
    if (MOTOR_VAR) begin
      for (int i = 0; i < NUM_ENC; i++) begin
        src[CODE_ENC_LO + i] = enc_filt_i[i];      // [RL10]
      end
    end
    for (int i = 0; i < NUM_RP; i++) begin
      if (CODE_PIN_LO + i <= int'(CODE_PIN_HI)) begin
        src[CODE_PIN_LO + i] = pad_filt[i];        // [RL1] [RL6]
      end
    end
  end

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  logic [15:0]      dir_q;
  logic [15:0]      lat_q;
  logic [15:0]      odc_q;
  logic [15:0]      cnen_q;
  logic [15:0]      pu_q;
  logic [15:0]      pd_q;
  logic [15:0]      ansel_q;
  logic [SEL_W-1:0] sel_q      [NUM_SEL];
  logic [15:0]      next_dir;
  logic [15:0]      next_lat;
  logic [15:0]      next_odc;
  logic [15:0]      next_cnen;
  logic [15:0]      next_pu;
  logic [15:0]      next_pd;
  logic [15:0]      next_ansel;
  logic [SEL_W-1:0] next_sel   [NUM_SEL];
  logic [15:0]      pin_rd;
  logic [15:0]      wm;
  logic             wr;

  assign wm     = lane_mask(sel_i);
  assign wr     = cyc_i && stb_i && we_i && !ack_o;
  assign pin_rd = pad_filt[NUM_RP +: 16] & ~ansel_q;

  always_comb begin
    next_dir   = dir_q;
    next_lat   = lat_q;
    next_odc   = odc_q;
    next_cnen  = cnen_q;
    next_pu    = pu_q;
    next_pd    = pd_q;
    next_ansel = ansel_q;
    for (int i = 0; i < NUM_SEL; i++) begin
      next_sel[i] = sel_q[i];
    end
    if (wr) begin
      if (hit(adr_i, IDX_DIRB)) begin
        next_dir = (dir_q & ~wm) | (dat_i[15:0] & wm);
      end
      if (hit(adr_i, IDX_PORTRD) || hit(adr_i, IDX_LATCH)) begin
        next_lat = (lat_q & ~wm) | (dat_i[15:0] & wm);
      end
      if (hit(adr_i, IDX_ODRAIN)) begin
        next_odc = (odc_q & ~wm) | (dat_i[15:0] & wm);
      end
      if (hit(adr_i, IDX_CNEN)) begin
        next_cnen = (cnen_q & ~wm) | (dat_i[15:0] & wm);
      end
      if (hit(adr_i, IDX_PULLUP)) begin
        next_pu = (pu_q & ~wm) | (dat_i[15:0] & wm);
      end
      if (hit(adr_i, IDX_PULLDN)) begin
        next_pd = (pd_q & ~wm) | (dat_i[15:0] & wm);
      end
      if (hit(adr_i, IDX_ANSEL)) begin
        next_ansel = ((ansel_q & ~wm) | (dat_i[15:0] & wm))
                     & ANSEL_MASK;                 // [RL14]
      end
      for (int i = 0; i < NUM_SEL; i++) begin
        if (hit(adr_i, IDX_SEL_BASE + 12'(i)) && sel_i[0]) begin
          next_sel[i] = dat_i[SEL_W-1:0];          // [RL4] [RL5]
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_q   <= RST_DIR;
      odc_q   <= RST_ZERO;
      cnen_q  <= RST_ZERO;
      pu_q    <= RST_ZERO;
      pd_q    <= RST_ZERO;
      ansel_q <= RST_ANSEL;                        // [RL14]
      for (int i = 0; i < NUM_SEL; i++) begin
        sel_q[i] <= RST_SEL;
      end
    end else begin
      dir_q   <= next_dir;
      odc_q   <= next_odc;
      cnen_q  <= next_cnen;
      pu_q    <= next_pu;
      pd_q    <= next_pd;
      ansel_q <= next_ansel;
      for (int i = 0; i < NUM_SEL; i++) begin
        sel_q[i] <= next_sel[i];
      end
    end
  end

  // The output latch is left without reset on purpose. [RL13]
  always_ff @(posedge clk_i) begin
    lat_q <= next_lat;
  end

  // --------------------------------------------------------------------------
  // Bus answer: one wait state, ack for one cycle, unmapped reads zero
  // --------------------------------------------------------------------------
  logic [31:0] next_dat;
  logic        next_ack;

  always_comb begin
    next_ack = cyc_i && stb_i && !ack_o;
    next_dat = '0;
    if (hit(adr_i, IDX_DIRB)) begin
      next_dat[15:0] = dir_q;
    end
    if (hit(adr_i, IDX_PORTRD)) begin
      next_dat[15:0] = pin_rd;
    end
    if (hit(adr_i, IDX_LATCH)) begin
      next_dat[15:0] = lat_q;
    end
    if (hit(adr_i, IDX_ODRAIN)) begin
      next_dat[15:0] = odc_q;
    end
    if (hit(adr_i, IDX_CNEN)) begin
      next_dat[15:0] = cnen_q;
    end
    if (hit(adr_i, IDX_PULLUP)) begin
      next_dat[15:0] = pu_q;
    end
    if (hit(adr_i, IDX_PULLDN)) begin
      next_dat[15:0] = pd_q;
    end
    if (hit(adr_i, IDX_ANSEL)) begin
      next_dat[15:0] = ansel_q & ANSEL_MASK;       // [RL14]
    end
    for (int i = 0; i < NUM_SEL; i++) begin
      if (hit(adr_i, IDX_SEL_BASE + 12'(i))) begin
        next_dat[SEL_W-1:0] = sel_q[i];            // [RL5]
      end
    end
    if (!(cyc_i && stb_i && !we_i)) begin
      next_dat = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= next_ack;
      dat_o <= next_dat;
    end
  end

  // --------------------------------------------------------------------------
  // Peripheral inputs, one independent selector each
  // --------------------------------------------------------------------------
  logic [NUM_SEL-1:0] next_pin;

  // Each slot indexes the shared source vector on its own. [RL2]
  for (genvar g = 0; g < NUM_SEL; g++) begin : g_route
    assign next_pin[g] = src[sel_q[g]];            // [RL1] [RL4] [RL11]
  end

  // --------------------------------------------------------------------------
  // Port B drive and change notice
  // --------------------------------------------------------------------------
  logic [15:0] cn_prev;
  logic        next_cn;

  always_comb begin
    next_cn = |((pin_rd ^ cn_prev) & cnen_q);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      periph_in_o <= '0;
      cn_prev     <= RST_ZERO;
      cn_change_o <= 1'b0;
    end else begin
      periph_in_o <= next_pin;
      cn_prev     <= pin_rd;
      cn_change_o <= next_cn;
    end
  end

  // Open-drain pins only drive low; a high latch releases the pad.
  assign port_b_pin_read_oe_o    = ~dir_q & ~(odc_q & lat_q);
  assign port_b_pin_read_out_o   = lat_q & port_b_pin_read_oe_o;
  assign port_b_pin_read_pu_o    = pu_q;
  assign port_b_pin_read_pd_o    = pd_q;
  assign port_b_pin_read_ansel_o = ansel_q;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_ack_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  a_ack_after_req: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o)
    else $error("request not answered in one cycle");

  a_vss_tie_low: assert property (@(posedge clk_i) disable iff (rst_i) // [RL8]
    (sel_q[SLOT_FAULT_A] == CODE_VSS) |=> !periph_in_o[SLOT_FAULT_A])
    else $error("code zero did not give low");

  a_comparator_one_output_fault_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RL7]
    (sel_q[SLOT_FAULT_A] == CODE_CMP_ONE)
      |=> periph_in_o[SLOT_FAULT_A] == $past(cmp_out_i[0]))
    else $error("fault A not following comparator one");

  a_comparator_one_output_pwm_flt: assert property (@(posedge clk_i) disable iff (rst_i) // [RL11]
    (sel_q[SLOT_FLT1] == CODE_CMP_ONE)
      |=> periph_in_o[SLOT_FLT1] == $past(cmp_out_i[0]))
    else $error("PWM fault 1 not following comparator one");

  a_pin_121_select: assert property (@(posedge clk_i) disable iff (rst_i) // [RL6]
    (sel_q[SLOT_FAULT_A] == CODE_PIN_HI)
      |=> periph_in_o[SLOT_FAULT_A] == $past(pad_filt[NUM_RP-1]))
    else $error("code 121 did not follow pin 121");

  a_unmapped_low: assert property (@(posedge clk_i) disable iff (rst_i) // [RL15]
    (sel_q[SLOT_FLT1] > CODE_PIN_HI) |=> !periph_in_o[SLOT_FLT1])
    else $error("unused code did not give low");

  a_sel_read_back: assert property (@(posedge clk_i) disable iff (rst_i) // [RL5]
    (cyc_i && stb_i && !we_i && !ack_o && hit(adr_i, IDX_SEL_BASE))
      |=> (dat_o[31:7] == '0) && (dat_o[6:0] == sel_q[SLOT_FAULT_A]))
    else $error("fault A register read back wrong");

  a_ansel_reset: assert property (@(posedge clk_i) // [RL14]
    $past(rst_i) && !rst_i |-> ansel_q == RST_ANSEL)
    else $error("analog select reset value wrong");

endmodule

// File: sim/pis_far_side.sv
// Far-side model: remappable pads, port B pads and on-chip sources.
// Assumes the bench sets src_i with one bit per selector code on clk_i.
module pis_far_side
  import pis_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic [127:0]       src_i,
  input  wire logic [15:0]        ext_i,
  input  wire logic [15:0]        oe_i,
  input  wire logic [15:0]        out_i,
  input  wire logic [15:0]        pu_i,
  input  wire logic [15:0]        pd_i,
  output logic      [101:0]       rp_pad_o,
  output logic      [NUM_CMP-1:0] cmp_o,
  output logic      [NUM_TRG-1:0] trg_o,
  output logic      [NUM_ENC-1:0] enc_o,
  output logic      [15:0]        port_b_pin_read_pad_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pads change without regard to the clock.
  assign rp_pad_o = src_i[121:20];
  // On-chip sources are logic on the same clock.
  always_ff @(posedge clk_i) begin
    cmp_o <= src_i[4:1];
    trg_o <= src_i[9:6];
    // The encoder is taken as enabled and fed from a pin.
    enc_o <= src_i[13:10];
  end
  // A released pin follows its pull, or the outside level.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      port_b_pin_read_pad_o[i] = oe_i[i] ? out_i[i] :
                       pu_i[i] ? 1'b1 : pd_i[i] ? 1'b0 : ext_i[i];
    end
  end
endmodule

// File: sim/tb_pis_input_select.sv
// Self-checking bench for the input selector and port B registers.
// Assumes the far-side model in pis_far_side and a 25 MHz clock.
module tb_pis_input_select
  import pis_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, cn_change_o;
  logic [15:0]  adr_i, port_b_pin_read_pad_i, port_b_pin_read_out_o, port_b_pin_read_oe_o, ext;
  logic [15:0]  port_b_pin_read_pu_o, port_b_pin_read_pd_o, port_b_pin_read_ansel_o;
  logic [31:0]  dat_i, dat_o;
  logic [3:0]   sel_i, periph_in_o, cmp_out_i, trg_out_i, enc_filt_i;
  logic [101:0] rp_pad_i;
  logic [127:0] src;
  int           mismatches, samples_checked;

  pis_input_select DUT (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .rp_pad_i(rp_pad_i),
    .cmp_out_i(cmp_out_i), .trg_out_i(trg_out_i),
    .enc_filt_i(enc_filt_i), .periph_in_o(periph_in_o),
    .port_b_pin_read_pad_i(port_b_pin_read_pad_i), .port_b_pin_read_out_o(port_b_pin_read_out_o),
    .port_b_pin_read_oe_o(port_b_pin_read_oe_o), .port_b_pin_read_pu_o(port_b_pin_read_pu_o),
    .port_b_pin_read_pd_o(port_b_pin_read_pd_o), .port_b_pin_read_ansel_o(port_b_pin_read_ansel_o),
    .cn_change_o(cn_change_o)
  );
  pis_far_side far (
    .clk_i(clk_i), .src_i(src), .ext_i(ext), .oe_i(port_b_pin_read_oe_o),
    .out_i(port_b_pin_read_out_o), .pu_i(port_b_pin_read_pu_o), .pd_i(port_b_pin_read_pd_o),
    .rp_pad_o(rp_pad_i), .cmp_o(cmp_out_i), .trg_o(trg_out_i),
    .enc_o(enc_filt_i), .port_b_pin_read_pad_o(port_b_pin_read_pad_i)
  );

  always #20 clk_i = ~clk_i;

  // --------------------------------------------------------------------------
  // Bus and compare helpers
  // --------------------------------------------------------------------------
  task automatic wb(input logic w, input logic [15:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n = 0;
    adr_i <= a;
    dat_i <= d;
    we_i  <= w;
    sel_i <= 4'hF;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    // Ack is registered, so its level mid-cycle is the one the next edge sees.
    do begin
      @(negedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, ack_o, 1'b1);
    end
    q = dat_o;
    @(posedge clk_i);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic rdc(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset;
    rdc(16'h3840, 32'h0000FFFF);
    rdc(16'h3858, 32'h0);
    rdc(16'h3878, 32'h0000010F);
    chk({16'h0, port_b_pin_read_ansel_o}, 32'h0000010F);
    rdc(16'h1A00, 32'h0);
    chk({28'h0, periph_in_o}, 32'h0);
  endtask

  task automatic t_masks;
    wr(16'h3878, 32'h0000FFFF);
    rdc(16'h3878, 32'h0000010F);
    wr(16'h1A00, 32'h0000FFFF);
    rdc(16'h1A00, 32'h0000007F);
    wr(16'h0100, 32'h0000FFFF);
    rdc(16'h0100, 32'h0);
    wr(16'h3840, 32'h0000FFFE);
    wr(16'h3848, 32'h00000001);
    chk({16'h0, port_b_pin_read_oe_o & port_b_pin_read_out_o}, 32'h00000001);
    wr(16'h3840, 32'h0000FFFF);
  endtask

  // Live codes see only their own source; dead ones see all sources high.
  task automatic route(input int s, input logic [6:0] c, input logic live);
    wr(16'h1A00 + 16'(4 * s), {25'h0, c});
    src <= live ? (128'h1 << c) : ~128'h0;
    repeat (7) @(posedge clk_i);
    chk({31'h0, periph_in_o[s]}, {31'h0, live});
    src <= ~(128'h1 << c);
    repeat (7) @(posedge clk_i);
    chk({31'h0, periph_in_o[s]}, 32'h0);
  endtask

  task automatic t_shared;
    wr(16'h1A08, 32'h00000030);
    wr(16'h1A0C, 32'h00000030);
    src <= 128'h1 << 48;
    repeat (7) @(posedge clk_i);
    chk({30'h0, periph_in_o[3:2]}, 32'h00000003);
  endtask

  // Pin read, pulls and change notice on port B, all pins inputs.
  task automatic t_port_b_pin_read;
    int seen;
    wr(16'h3868, 32'h00000003);
    chk({16'h0, port_b_pin_read_pu_o}, 32'h00000003);
    wr(16'h3868, 32'h00000000);
    wr(16'h3870, 32'h00000005);
    chk({16'h0, port_b_pin_read_pd_o}, 32'h00000005);
    wr(16'h3870, 32'h00000000);
    rdc(16'h3848, 32'h0000A4A0);
    wr(16'h3860, 32'h00000010);
    seen = 0;
    ext <= 16'hA5B5;
    repeat (10) begin
      @(negedge clk_i);
      if (cn_change_o === 1'b1) seen++;
    end
    chk(seen, 32'h1);
    rdc(16'h3848, 32'h0000A4B0);
  endtask

  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    {we_i, cyc_i, stb_i} = 3'b000;
    adr_i = 16'h0;
    dat_i = 32'h0;
    sel_i = 4'h0;
    src = 128'h0;
    ext = 16'hA5A5;
    mismatches = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset;
    t_masks;
    route(0, 7'h79, 1'b1);
    route(0, 7'h14, 1'b1);
    route(0, 7'h01, 1'b1);
    route(1, 7'h01, 1'b1);
    route(2, 7'h03, 1'b1);
    route(2, 7'h06, 1'b1);
    route(3, 7'h0D, 1'b1);
    route(0, 7'h00, 1'b0);
    route(1, 7'h05, 1'b0);
    route(3, 7'h7F, 1'b0);
    t_shared;
    t_port_b_pin_read;
    end_of_test;
  end

  initial begin
    #400000;
    mismatches++;
    end_of_test;
  end

  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
endmodule
